// File: hw/dma_channel_defs.vh
// Constants for the single DMA channel: register map, fields, encodings
`ifndef DMA_CHANNEL_DEFS_VH
`define DMA_CHANNEL_DEFS_VH

`define REG_SRC_PTR      8'h00
`define REG_DST_PTR      8'h04
`define REG_CTRL         8'h08
`define REG_COUNT        8'h0C
`define REG_STATUS       8'h10

`define CTRL_INT_EN      31
`define CTRL_EXT_EN      30
`define CTRL_SINGLE      29
`define CTRL_ALIGN       28
`define CTRL_BW_HI       27
`define CTRL_BW_LO       25
`define CTRL_ONE_ADDR    24
`define CTRL_ONE_DIR     23
`define CTRL_SRC_ADV     22
`define CTRL_SW_HI       21
`define CTRL_SW_LO       20
`define CTRL_DST_ADV     19
`define CTRL_DW_HI       18
`define CTRL_DW_LO       17
`define CTRL_START       16
`define CTRL_ACK_SCOPE   15
`define CTRL_RSVD_MASK   32'hFFFE_8000
`define CTRL_RESET       32'h0000_0000

`define ST_CE            6
`define ST_BES           5
`define ST_BED           4
`define ST_BUSY          1
`define ST_DONE          0

`define WIDTH_LONG       2'h0
`define WIDTH_BYTE       2'h1
`define WIDTH_WORD       2'h2
`define WIDTH_LINE       2'h3

`define BW_BLOCK_BASE    24'h00_2000

`endif

// File: hw/dma_channel_control.v
// One DMA channel: APB control registers and system bus transfer engine
`timescale 1ns/100ps
`default_nettype none
`include "dma_channel_defs.vh"

module dma_channel_control #(
    parameter CNT_W = 24
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        pclken,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        ext_transfer_request,
    output wire        bus_request,
    output wire        sys_valid,
    output wire [31:0] sys_addr,
    output wire        sys_read,
    output wire [1:0]  sys_width,
    output wire [31:0] sys_wdata,
    input  wire [31:0] sys_rdata,
    input  wire        sys_done,
    input  wire        sys_err,
    output wire        dma_ack,
    output wire        irq
);

    localparam S_IDLE = 5'b00001;
    localparam S_RD   = 5'b00010;
    localparam S_WR   = 5'b00100;
    localparam S_SGL  = 5'b01000;
    localparam S_GAP  = 5'b10000;

    reg [4:0]       state_ff;
    reg [4:0]       nxt_state;
    reg [31:0]      ctrl_ff;
    reg             start_ff;
    reg [31:0]      src_ff;
    reg [31:0]      dst_ff;
    reg [CNT_W-1:0] count_ff;
    reg [31:0]      hold_ff;
    reg             active_ff;
    reg             ext_sel_ff;
    reg             done_ff;
    reg             ce_ff;
    reg             bes_ff;
    reg             bed_ff;

    // Bytes moved by one bus cycle of a given width code
    function [4:0] width_bytes;
        input [1:0] code;
        begin
            case (code)
                `WIDTH_BYTE: width_bytes = 5'h01;
                `WIDTH_WORD: width_bytes = 5'h02;
                `WIDTH_LINE: width_bytes = 5'h10;
                default:     width_bytes = 5'h04;
            endcase
        end
    endfunction

    wire [1:0] src_w = ctrl_ff[`CTRL_SW_HI:`CTRL_SW_LO];
    wire [1:0] dst_w = ctrl_ff[`CTRL_DW_HI:`CTRL_DW_LO];
    wire [2:0] bw    = ctrl_ff[`CTRL_BW_HI:`CTRL_BW_LO];
    wire [4:0] src_b = width_bytes(src_w);
    wire [4:0] dst_b = width_bytes(dst_w);
    wire       single_mode = ctrl_ff[`CTRL_ONE_ADDR];
    wire       steal_mode  = ctrl_ff[`CTRL_SINGLE];

    // A transfer moves the larger of the two widths
    wire [4:0] xfer_b = (src_b >= dst_b) ? src_b : dst_b;
    wire [CNT_W-1:0] xfer_cnt = {{(CNT_W-5){1'b0}}, xfer_b};

    wire align_src = ctrl_ff[`CTRL_ALIGN] & (src_b >= dst_b);
    wire align_dst = ctrl_ff[`CTRL_ALIGN] & ~align_src;
    wire src_inc   = ctrl_ff[`CTRL_SRC_ADV] | align_src;
    wire dst_inc   = ctrl_ff[`CTRL_DST_ADV] | align_dst;

    wire ext_go  = ctrl_ff[`CTRL_EXT_EN] & ext_transfer_request;
    wire req_any = start_ff | ext_go;
    wire size_bad = (count_ff & (xfer_cnt - {{(CNT_W-1){1'b0}}, 1'b1}))
                    != {CNT_W{1'b0}};
    wire cnt_zero = (count_ff == {CNT_W{1'b0}});

    wire [CNT_W-1:0] cnt_after = count_ff - xfer_cnt;
    wire [CNT_W-1:0] blk_mask  = (`BW_BLOCK_BASE << bw) - 24'h00_0001;
    wire at_block = (bw != 3'h0) &&
                    ((cnt_after & blk_mask) == {CNT_W{1'b0}});

    wire in_cycle = (state_ff == S_RD) | (state_ff == S_WR) |
                    (state_ff == S_SGL);
    wire cyc_ok   = in_cycle & sys_done & ~sys_err;
    wire cyc_err  = in_cycle & sys_done & sys_err;
    wire xfer_end = cyc_ok & ((state_ff == S_WR) | (state_ff == S_SGL));
    wire last_xfer = (count_ff == xfer_cnt);

    // Launch decision in idle: first request checks configuration
    wire launch_new = (state_ff == S_IDLE) & ~active_ff & req_any;
    wire cfg_fail   = launch_new & (size_bad | cnt_zero);
    wire launch = (state_ff == S_IDLE) &
                  ((launch_new & ~size_bad & ~cnt_zero) |
                   (active_ff & steal_mode & req_any) |
                   (active_ff & ~steal_mode));

    // APB slave: no wait states, unmapped offsets answer with an error
    wire apb_setup = psel & ~penable;
    wire apb_wr    = psel & penable & pwrite & pclken;
    wire mapped = (paddr == `REG_SRC_PTR) | (paddr == `REG_DST_PTR) |
                  (paddr == `REG_CTRL) | (paddr == `REG_COUNT) |
                  (paddr == `REG_STATUS);
    assign pready  = psel & penable;
    assign pslverr = psel & penable & ~mapped;

    wire wr_src   = apb_wr & (paddr == `REG_SRC_PTR);
    wire wr_dst   = apb_wr & (paddr == `REG_DST_PTR);
    wire wr_ctrl  = apb_wr & (paddr == `REG_CTRL);
    wire wr_count = apb_wr & (paddr == `REG_COUNT);
    // Writing one to done aborts the channel and clears all status
    wire clr_stat = apb_wr & (paddr == `REG_STATUS) & pwdata[`ST_DONE];

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            S_IDLE: begin
                if (launch) begin
                    nxt_state = single_mode ? S_SGL : S_RD;
                end
            end
            S_RD: begin
                if (cyc_err) begin
                    nxt_state = S_IDLE;
                end else if (cyc_ok) begin
                    nxt_state = S_WR;
                end
            end
            S_WR, S_SGL: begin
                if (cyc_err) begin
                    nxt_state = S_IDLE;
                end else if (xfer_end) begin
                    if (!last_xfer && !steal_mode && at_block) begin
                        nxt_state = S_GAP;
                    end else begin
                        nxt_state = S_IDLE;
                    end
                end
            end
            S_GAP: begin
                nxt_state = S_IDLE;
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
        if (clr_stat) begin
            nxt_state = S_IDLE;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff   <= S_IDLE;
            ctrl_ff    <= `CTRL_RESET;
            start_ff   <= 1'b0;
            src_ff     <= 32'h0000_0000;
            dst_ff     <= 32'h0000_0000;
            count_ff   <= {CNT_W{1'b0}};
            hold_ff    <= 32'h0000_0000;
            active_ff  <= 1'b0;
            ext_sel_ff <= 1'b0;
            done_ff    <= 1'b0;
            ce_ff      <= 1'b0;
            bes_ff     <= 1'b0;
            bed_ff     <= 1'b0;
            prdata     <= 32'h0000_0000;
        end else if (pclken) begin
            state_ff <= nxt_state;
            if (wr_ctrl) begin
                ctrl_ff <= pwdata & `CTRL_RSVD_MASK;
            end
            // Start lives one clock only and is never stored in ctrl
            start_ff <= wr_ctrl & pwdata[`CTRL_START];
            if (launch) begin
                ext_sel_ff <= ~start_ff & ext_go;
            end
            // Dual-address cycles hold the read data for the write cycle that follows
            if (cyc_ok && state_ff == S_RD) begin
                hold_ff <= sys_rdata;
            end
            if (wr_src) begin
                src_ff <= pwdata;
            end else if (xfer_end && src_inc) begin
                src_ff <= src_ff + {27'h000_0000, xfer_b};
            end
            if (wr_dst) begin
                dst_ff <= pwdata;
            end else if (xfer_end && dst_inc && !single_mode) begin
                dst_ff <= dst_ff + {27'h000_0000, xfer_b};
            end
            if (wr_count) begin
                count_ff <= pwdata[CNT_W-1:0];
            end else if (xfer_end) begin
                count_ff <= cnt_after;
            end
            // Busy spans from the first launch to the last transfer
            if (clr_stat || cyc_err || (xfer_end && last_xfer)) begin
                active_ff <= 1'b0;
            end else if (launch_new && !cfg_fail) begin
                active_ff <= 1'b1;
            end
            // Hardware set beats a simultaneous software clear
            done_ff <= (xfer_end & last_xfer) | (done_ff & ~clr_stat);
            ce_ff   <= cfg_fail | (ce_ff & ~clr_stat);
            bes_ff  <= (cyc_err & (state_ff != S_WR)) |
                       (bes_ff & ~clr_stat);
            bed_ff  <= (cyc_err & (state_ff == S_WR)) |
                       (bed_ff & ~clr_stat);
            if (apb_setup) begin
                case (paddr)
                    `REG_SRC_PTR: prdata <= src_ff;
                    `REG_DST_PTR: prdata <= dst_ff;
                    `REG_CTRL:    prdata <= ctrl_ff;
                    `REG_COUNT:   prdata <= {{(32-CNT_W){1'b0}}, count_ff};
                    `REG_STATUS: begin
                        prdata <= 32'h0000_0000;
                        prdata[`ST_CE]   <= ce_ff;
                        prdata[`ST_BES]  <= bes_ff;
                        prdata[`ST_BED]  <= bed_ff;
                        prdata[`ST_BUSY] <= active_ff;
                        prdata[`ST_DONE] <= done_ff;
                    end
                    default:      prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Request drops in the gap state and when busy clears; with code zero it never gaps
    assign bus_request = active_ff & (state_ff != S_GAP);
    assign sys_valid   = in_cycle;
    assign sys_addr    = (state_ff == S_WR) ? dst_ff : src_ff;
    assign sys_read    = (state_ff == S_SGL) ?
                         ctrl_ff[`CTRL_ONE_DIR] :
                         (state_ff == S_RD);
    assign sys_width   = (state_ff == S_WR) ? dst_w :
                         ((state_ff == S_SGL) ? xfer_w_code(src_w, dst_w)
                                              : src_w);
    assign sys_wdata   = hold_ff;
    // Scope one limits acknowledge to the last transfer, both cycles
    assign dma_ack = in_cycle & ext_sel_ff &
                     (~ctrl_ff[`CTRL_ACK_SCOPE] | last_xfer);
    assign irq = ctrl_ff[`CTRL_INT_EN] &
                 (done_ff | ce_ff | bes_ff | bed_ff);

    // Width code of the larger side, for single-address cycles
    function [1:0] xfer_w_code;
        input [1:0] a;
        input [1:0] b;
        begin
            xfer_w_code = (width_bytes(a) >= width_bytes(b)) ? a : b;
        end
    endfunction

endmodule
`default_nettype wire

// File: tb/dma_channel_control_checker.sv
// Port-level assertions for the DMA channel
`timescale 1ns/100ps
`default_nettype none
module dma_channel_control_checker (
    input wire logic        pclk, presetn, pclken, psel, penable, pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata, prdata, sys_addr, sys_wdata, sys_rdata,
    input wire logic        pready, pslverr, ext_transfer_request,
    input wire logic        bus_request, sys_valid, sys_read, sys_done,
    input wire logic        sys_err, dma_ack, irq,
    input wire logic [1:0]  sys_width
);
    wire logic acc = psel && penable;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_match_a: assert property (pready == acc)
        else $error("pready not tied to access phase");
    slverr_scope_a: assert property (pslverr |-> acc)
        else $error("pslverr outside access phase");
    unmapped_read_a: assert property (acc && paddr > 8'h10 |->
        pslverr && prdata == 32'h0) else $error("unmapped access not refused");
    ctrl_read_zero_a: assert property (acc && !pwrite && paddr == 8'h08 |->
        !prdata[16] && prdata[14:0] == 15'h0) else $error("start or spare bit read 1");
    cycle_hold_a: assert property (sys_valid && !sys_done |=> sys_valid &&
        $stable(sys_addr) && $stable(sys_width) && $stable(sys_read))
        else $error("bus cycle changed before done");
    busreq_held_a: assert property (sys_valid |-> bus_request)
        else $error("bus request low during cycle");
    ack_in_cycle_a: assert property (dma_ack |-> sys_valid)
        else $error("acknowledge outside bus cycle");
    err_stop_a: assert property (sys_valid && sys_done && sys_err |=>
        !sys_valid [*2]) else $error("channel went on after bus error");
    cover property (sys_valid && sys_done && sys_err);
    cover property ($fell(bus_request) ##1 bus_request);
    cover property (dma_ack && sys_done);
endmodule
bind dma_channel_control dma_channel_control_checker
    dma_channel_control_checker_inst (.*);
`default_nettype wire

// File: tb/sys_bus_model.sv
// System bus slave model with optional wait states and bus errors
`timescale 1ns/100ps
`default_nettype none
module sys_bus_model (
    input  wire logic        pclk, presetn, sys_valid, sys_read, slow, err_next,
    input  wire logic [31:0] sys_addr, sys_wdata,
    output logic             sys_done, sys_err, last_read,
    output logic [31:0]      sys_rdata, last_addr, last_wdata,
    output int               ncyc
);
    int wait_cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_done <= 1'b0;
            sys_err <= 1'b0;
            sys_rdata <= 32'h0;
            wait_cnt <= 0;
        end else if (sys_valid && !sys_done && wait_cnt >= (slow ? 3 : 0)) begin
            sys_done <= 1'b1;
            sys_err <= err_next;
            sys_rdata <= sys_addr ^ 32'hA5A5_0000;
            wait_cnt <= 0;
        end else begin
            sys_done <= 1'b0;
            sys_err <= 1'b0;
            // Idle data bus keeps changing so a stale capture shows up
            sys_rdata <= ~sys_rdata;
            wait_cnt <= (sys_valid && !sys_done) ? wait_cnt + 1 : 0;
        end
    end
    always @(posedge pclk) begin
        if (sys_valid && sys_done) begin
            ncyc <= ncyc + 1;
            last_addr <= sys_addr;
            last_read <= sys_read;
            last_wdata <= sys_wdata;
        end
    end
endmodule
`default_nettype wire

// File: tb/dma_channel_control_tb_top.sv
// Register-level testbench for the DMA channel
`timescale 1ns/100ps
`default_nettype none
`include "dma_channel_defs.vh"
module dma_channel_control_tb_top;
    logic pclk = 0, presetn = 0, pclken = 1, psel = 0, penable = 0, pwrite = 0;
    logic ext_transfer_request = 0, slow = 0, err_next = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, sys_addr, sys_wdata, sys_rdata;
    logic [31:0] last_addr, last_wdata, rdat;
    logic pready, pslverr, bus_request, sys_valid, sys_read, sys_done;
    logic sys_err, dma_ack, irq, last_read, slv, br_q = 0;
    logic [1:0] sys_width;
    int ncyc, errors = 0, checks_done = 0, falls = 0, f0;
    dma_channel_control dma_channel_control_inst (.*);
    sys_bus_model sys_bus_model_inst (.*);
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) begin
        br_q <= bus_request;
        if (br_q && !bus_request) falls <= falls + 1;
    end
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        for (n = 0; pready !== 1'b1; n++) begin
            if (n > 20) begin errors++; test_done(); end
            @(posedge pclk);
        end
        rdat = prdata;
        slv = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(rdat, e);
    endtask
    task wait_end;
        int n;
        for (n = 0; n < 3000; n++) begin
            apb(0, `REG_STATUS, 32'h0);
            if (|{rdat[6:4], rdat[0]}) return;
        end
        errors++;
        test_done();
    endtask
    task xfer(input logic [31:0] s, d, c, ctl);
        apb(1, `REG_SRC_PTR, s);
        apb(1, `REG_DST_PTR, d);
        apb(1, `REG_COUNT, c);
        apb(1, `REG_CTRL, ctl);
    endtask
    task clr(input string s);
        apb(1, `REG_STATUS, 32'h1);
        $display("test %s done", s);
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        rd(`REG_CTRL, 32'h0);
        pclken <= 0;
        apb(1, `REG_SRC_PTR, 32'h55);
        pclken <= 1;
        rd(`REG_SRC_PTR, 32'h0);
        apb(1, `REG_CTRL, 32'hFFFE_FFFF);
        rd(`REG_CTRL, 32'hFFFE_8000);
        apb(0, 8'h14, 32'h0);
        chk({31'h0, slv}, 32'h1);
        apb(1, `REG_CTRL, 32'hFFFF_FFFF);
        rd(`REG_CTRL, 32'hFFFE_8000);
        rd(`REG_STATUS, 32'h40);
        chk({31'h0, irq}, 32'h1);
        clr("registers");
        f0 = falls;
        xfer(32'h100, 32'h200, 32'h8, 32'h8041_0000);
        wait_end();
        rd(`REG_SRC_PTR, 32'h108);
        rd(`REG_DST_PTR, 32'h200);
        rd(`REG_COUNT, 32'h0);
        chk(last_wdata, 32'hA5A5_0104);
        chk(32'(falls - f0), 32'h1);
        chk({31'h0, irq}, 32'h1);
        clr("continuous");
        xfer(32'h100, 32'h200, 32'h8, 32'h1011_0000);
        wait_end();
        rd(`REG_DST_PTR, 32'h208);
        rd(`REG_SRC_PTR, 32'h100);
        chk({31'h0, irq}, 32'h0);
        clr("align");
        f0 = falls;
        xfer(32'h0, 32'h0, 32'h4010, 32'h0237_0000);
        wait_end();
        chk(32'(falls - f0), 32'h2);
        clr("bandwidth");
        slow <= 1;
        xfer(32'h100, 32'h0, 32'h8, 32'h6040_0000);
        f0 = ncyc;
        ext_transfer_request <= 1;
        @(posedge pclk);
        ext_transfer_request <= 0;
        repeat (40) @(posedge pclk);
        chk(32'(ncyc - f0), 32'h2);
        rd(`REG_COUNT, 32'h4);
        apb(1, `REG_CTRL, 32'h2040_0000);
        ext_transfer_request <= 1;
        repeat (20) @(posedge pclk);
        ext_transfer_request <= 0;
        rd(`REG_COUNT, 32'h4);
        apb(1, `REG_CTRL, 32'h2041_0000);
        wait_end();
        rd(`REG_STATUS, 32'h1);
        slow <= 0;
        clr("cycle steal");
        xfer(32'h300, 32'h0, 32'h4, 32'h0101_0000);
        wait_end();
        chk(last_addr, 32'h300);
        chk({31'h0, last_read}, 32'h0);
        clr("single write");
        xfer(32'h300, 32'h0, 32'h4, 32'h0181_0000);
        wait_end();
        chk({31'h0, last_read}, 32'h1);
        clr("single read");
        err_next <= 1;
        xfer(32'h100, 32'h200, 32'h4, 32'h0001_0000);
        wait_end();
        rd(`REG_STATUS, 32'h20);
        err_next <= 0;
        clr("bus error");
        test_done();
    end
endmodule
`default_nettype wire
